// ===== rtl/radio_modem_consts.vh
// constants for the radio modem command-mode handler
// included by rtl/radio_modem_command_mode.v only
`ifndef RADIO_MODEM_CONSTS_VH
`define RADIO_MODEM_CONSTS_VH
// timing, sized to the 24-bit cycle counters so the defaults need no cut
`define CLK_KHZ 24'h009c40
`define TICK_MS 24'h000064
`define PWM_SLOTS 24'h000040
// binary command codes, bit 7 of the first byte asks for a read
`define RD_FLAG 7
`define CMD_GUARD_BEFORE 7'h04
`define CMD_GUARD_AFTER 7'h05
`define CMD_IDLE_TIMEOUT 7'h06
`define CMD_SAVE 7'h08
`define CMD_LEAVE 7'h09
`define CMD_ECHO_DISABLE 7'h0a
`define CMD_ECHO_ENABLE 7'h0b
`define CMD_FACTORY_RESTORE 7'h0e
`define CMD_RX_ERR_COUNT 7'h0f
`define CMD_RX_GOOD_COUNT 7'h10
`define CMD_ESCAPE_CHAR 7'h13
`define CMD_POWER_UP_MODE 7'h1e
`define CMD_PWM_PERIOD 7'h22
// factory defaults
`define DEF_GUARD_AFTER 16'h000a
`define DEF_GUARD_BEFORE 16'h000a
`define DEF_ESCAPE_CHAR 8'h2b
`define DEF_IDLE_TIMEOUT 16'h00c8
`define DEF_POWER_UP_MODE 8'h00
`define DEF_PWM_PERIOD 8'h00
// legal ranges
`define ESC_MIN 8'h20
`define ESC_MAX 8'h7f
`define TIMEOUT_MIN 16'h0002
`define PUM_MAX 8'h01
`define PWM_MAX 8'h7f
`define ESC_COUNT 2'h3
// stored image layout, 72 bits
`define NV_W 72
`define NV_AT 71:56
`define NV_BT 55:40
`define NV_CT 39:24
`define NV_CC 23:16
`define NV_PC 15:8
`define NV_RP 7:0
`endif

// ===== rtl/radio_modem_command_mode.v
// command-mode handler of a serial radio modem: escape detection, parameter access, counters, pwm
// assumes byte-level serial in/out from a uart outside, and a non-volatile store behind the nvm ports
`timescale 1ns/100ps
`include "radio_modem_consts.vh"

// Summary of operation
// - the save command copies all current parameters to non-volatile storage for reload after reset.
// - the host stays silent for the guard-after time (16 bits, 100 ms units, default 0xa) after the escapes.
// - the host stays silent for the guard-before time (16 bits, 100 ms units, default 0xa) before the escapes.
// - the escape character is programmable from 0x20 to 0x7f and defaults to 0x2b.
// - idle goes to command mode only after guard-before silence, the escapes, then guard-after silence, or on wake when power-up mode is 1.
// - the leave command returns at once to idle mode.
// - command mode times out to idle when no valid command arrives within the timeout (min 0x02, default 0xc8).
// - the echo-disable command stops echo of received characters in command mode.
// - the echo-enable command echoes every received character in command mode.
// - after reset or wake the mode is idle when power-up mode is 0, command mode when it is 1.
// - a 16-bit count of packets dropped for bit errors, reset to 0, cleared by any write.
// - a 16-bit count of good packets, reset to 0, cleared by any write.
// - the restore command reloads every parameter with its factory default.
// - a non-zero pwm period drives a signal-strength pwm on the config pin, period in 100 ms units.
module radio_modem_command_mode #(
  parameter [23:0] TICK_CYCLES = `TICK_MS * `CLK_KHZ,
  parameter [23:0] SLOT_CYCLES = (`TICK_MS * `CLK_KHZ) / `PWM_SLOTS
) (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // bytes from the host on the serial input pin
  input wire rx_valid,
  input wire [7:0] rx_data,
  // bytes to the host on the serial output pin
  output wire tx_valid,
  output wire [7:0] tx_data,
  input wire tx_ready,
  // radio receive events
  input wire pkt_good,
  input wire pkt_err,
  input wire [5:0] pkt_rssi,
  // non-volatile store
  input wire nvm_present,
  input wire [`NV_W-1:0] nvm_rd_image,
  output wire nvm_save,
  output wire [`NV_W-1:0] nvm_wr_image,
  // power management
  input wire wake,
  // status and config pin
  output wire cmd_mode,
  output wire rssi_pwm
);

  localparam [2:0] ST_LOAD = 3'h0, ST_IDLE = 3'h1, ST_ESC = 3'h2, ST_CMD = 3'h3, ST_ARG = 3'h4;
  localparam [23:0] TICK_LAST = TICK_CYCLES - 24'h000001;
  localparam [23:0] SLOT_LAST = SLOT_CYCLES - 24'h000001;
  reg [2:0] st_ff;
  reg [15:0] guard_after_time_ff, guard_before_time_ff, command_idle_timeout_ff, silence_ff, age_ff, rv;
  reg [15:0] receive_error_counter_ff, receive_good_counter_ff;
  reg [7:0] escape_character_ff, power_up_mode_select_ff, signal_strength_pwm_period_ff;
  reg [7:0] arg_acc_ff, q0_ff, q1_ff, q2_ff;
  reg [23:0] tick_cnt_ff, slot_cnt_ff;
  reg [1:0] esc_cnt_ff, arg_left_ff, qn_ff, nxt_qn;
  reg [6:0] arg_code_ff, div_ff;
  reg [5:0] phase_ff, rssi_ff;
  reg echo_ff, save_ff, pwm_ff;
  reg [`NV_W-1:0] image_ff;
  // byte count of a parameter, zero for plain commands and unknown codes
  function [1:0] param_len;
    input [6:0] code;
    begin
      case (code)
        `CMD_GUARD_BEFORE, `CMD_GUARD_AFTER, `CMD_IDLE_TIMEOUT,
        `CMD_RX_ERR_COUNT, `CMD_RX_GOOD_COUNT: param_len = 2'h2;
        `CMD_ESCAPE_CHAR, `CMD_POWER_UP_MODE, `CMD_PWM_PERIOD: param_len = 2'h1;
        default: param_len = 2'h0;
      endcase
    end
  endfunction
  function [15:0] param_val;
    input [6:0] code;
    begin
      case (code)
        `CMD_GUARD_BEFORE: param_val = guard_before_time_ff;
        `CMD_GUARD_AFTER: param_val = guard_after_time_ff;
        `CMD_IDLE_TIMEOUT: param_val = command_idle_timeout_ff;
        `CMD_RX_ERR_COUNT: param_val = receive_error_counter_ff;
        `CMD_RX_GOOD_COUNT: param_val = receive_good_counter_ff;
        `CMD_ESCAPE_CHAR: param_val = {8'h00, escape_character_ff};
        `CMD_POWER_UP_MODE: param_val = {8'h00, power_up_mode_select_ff};
        `CMD_PWM_PERIOD: param_val = {8'h00, signal_strength_pwm_period_ff};
        default: param_val = 16'h0000;
      endcase
    end
  endfunction
  // out-of-range writes are refused and do not count as a valid command
  function arg_ok;
    input [6:0] code;
    input [15:0] val;
    begin
      case (code)
        `CMD_ESCAPE_CHAR: arg_ok = val[7:0] >= `ESC_MIN && val[7:0] <= `ESC_MAX;
        `CMD_IDLE_TIMEOUT: arg_ok = val >= `TIMEOUT_MIN;
        `CMD_POWER_UP_MODE: arg_ok = val[7:0] <= `PUM_MAX;
        `CMD_PWM_PERIOD: arg_ok = val[7:0] <= `PWM_MAX;
        default: arg_ok = 1'b1;
      endcase
    end
  endfunction
  function is_plain;
    input [6:0] code;
    begin
      case (code)
        `CMD_SAVE, `CMD_LEAVE, `CMD_ECHO_DISABLE, `CMD_ECHO_ENABLE, `CMD_FACTORY_RESTORE: is_plain = 1'b1;
        default: is_plain = 1'b0;
      endcase
    end
  endfunction
  wire tick_stb = tick_cnt_ff == TICK_LAST;
  wire [6:0] op_code = rx_data[6:0];
  wire op_read = rx_data[`RD_FLAG];
  wire in_cmd = st_ff == ST_CMD || st_ff == ST_ARG;
  wire timed_out = in_cmd && age_ff >= command_idle_timeout_ff;
  wire [15:0] wr_val = {arg_acc_ff, rx_data};
  wire wr_now = st_ff == ST_ARG && !timed_out && rx_valid && arg_left_ff == 2'h1 && arg_ok(arg_code_ff, wr_val);
  wire rd_now = st_ff == ST_CMD && !timed_out && rx_valid && op_read;
  wire [1:0] rd_len = rd_now ? param_len(op_code) : 2'h0;
  wire op_now = st_ff == ST_CMD && !timed_out && rx_valid && !op_read;
  wire cmd_valid = wr_now || rd_len != 2'h0 || (op_now && is_plain(op_code));
  wire clr_err = wr_now && arg_code_ff == `CMD_RX_ERR_COUNT;
  wire clr_good = wr_now && arg_code_ff == `CMD_RX_GOOD_COUNT;
  wire echo_now = in_cmd && !timed_out && rx_valid && echo_ff;
  // answer queue: echo byte first, then the read data high byte first
  reg [7:0] nxt_q0, nxt_q1, nxt_q2, r0, r1;
  always @* begin
    rv = param_val(op_code);
    r0 = rd_len == 2'h2 ? rv[15:8] : rv[7:0];
    r1 = rv[7:0];
    nxt_q0 = q0_ff;
    nxt_q1 = q1_ff;
    nxt_q2 = q2_ff;
    nxt_qn = qn_ff;
    if (tx_valid && tx_ready) begin
      nxt_q0 = q1_ff;
      nxt_q1 = q2_ff;
      nxt_qn = qn_ff - 2'h1;
    end
    // the host waits for the answer, so a push finds the queue drained
    if (echo_now) begin
      nxt_q0 = rx_data;
      nxt_q1 = r0;
      nxt_q2 = r1;
      nxt_qn = 2'h1 + rd_len;
    end else if (rd_len != 2'h0) begin
      nxt_q0 = r0;
      nxt_q1 = r1;
      nxt_qn = rd_len;
    end
  end
  // answer queue, time base, silence and command-age counters in 100 ms ticks, receive counters
  always @(posedge mclk) begin
    if (!rst_n) begin
      q0_ff <= 8'h00;
      q1_ff <= 8'h00;
      q2_ff <= 8'h00;
      qn_ff <= 2'h0;
      tick_cnt_ff <= 24'h000000;
      silence_ff <= 16'h0000;
      age_ff <= 16'h0000;
      receive_error_counter_ff <= 16'h0000;
      receive_good_counter_ff <= 16'h0000;
    end else begin
      q0_ff <= nxt_q0;
      q1_ff <= nxt_q1;
      q2_ff <= nxt_q2;
      qn_ff <= nxt_qn;
      tick_cnt_ff <= tick_stb ? 24'h000000 : tick_cnt_ff + 24'h000001;
      if (rx_valid)
        silence_ff <= 16'h0000;
      else if (tick_stb && silence_ff != 16'hffff)
        silence_ff <= silence_ff + 16'h0001;
      if (cmd_valid || !in_cmd)
        age_ff <= 16'h0000;
      else if (tick_stb && age_ff != 16'hffff)
        age_ff <= age_ff + 16'h0001;
      // receive counters saturate; a packet in the clearing cycle still counts
      if (clr_err)
        receive_error_counter_ff <= {15'h0000, pkt_err};
      else if (pkt_err && receive_error_counter_ff != 16'hffff)
        receive_error_counter_ff <= receive_error_counter_ff + 16'h0001;
      if (clr_good)
        receive_good_counter_ff <= {15'h0000, pkt_good};
      else if (pkt_good && receive_good_counter_ff != 16'hffff)
        receive_good_counter_ff <= receive_good_counter_ff + 16'h0001;
    end
  end
  // mode sequencer and parameter store
  always @(posedge mclk) begin
    if (!rst_n) begin
      st_ff <= ST_LOAD;
      guard_after_time_ff <= `DEF_GUARD_AFTER;
      guard_before_time_ff <= `DEF_GUARD_BEFORE;
      command_idle_timeout_ff <= `DEF_IDLE_TIMEOUT;
      escape_character_ff <= `DEF_ESCAPE_CHAR;
      power_up_mode_select_ff <= `DEF_POWER_UP_MODE;
      signal_strength_pwm_period_ff <= `DEF_PWM_PERIOD;
      echo_ff <= 1'b1;
      esc_cnt_ff <= 2'h0;
      arg_code_ff <= 7'h00;
      arg_left_ff <= 2'h0;
      arg_acc_ff <= 8'h00;
      save_ff <= 1'b0;
      image_ff <= {`NV_W{1'b0}};
    end else begin
      save_ff <= 1'b0;
      case (st_ff)
        ST_LOAD: begin
          // stored image sampled one cycle after reset release
          if (nvm_present) begin
            guard_after_time_ff <= nvm_rd_image[`NV_AT];
            guard_before_time_ff <= nvm_rd_image[`NV_BT];
            command_idle_timeout_ff <= nvm_rd_image[`NV_CT];
            escape_character_ff <= nvm_rd_image[`NV_CC];
            power_up_mode_select_ff <= nvm_rd_image[`NV_PC];
            signal_strength_pwm_period_ff <= nvm_rd_image[`NV_RP];
          end
          if (nvm_present && nvm_rd_image[`NV_PC] == `PUM_MAX)
            st_ff <= ST_CMD;
          else
            st_ff <= ST_IDLE;
        end
        ST_IDLE: begin
          if (rx_valid && rx_data == escape_character_ff && silence_ff >= guard_before_time_ff) begin
            st_ff <= ST_ESC;
            esc_cnt_ff <= 2'h1;
          end
        end
        ST_ESC: begin
          if (rx_valid) begin
            // a fourth escape or any other byte aborts the sequence
            if (rx_data == escape_character_ff && esc_cnt_ff != `ESC_COUNT)
              esc_cnt_ff <= esc_cnt_ff + 2'h1;
            else
              st_ff <= ST_IDLE;
          end else if (esc_cnt_ff == `ESC_COUNT && silence_ff >= guard_after_time_ff) begin
            st_ff <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (timed_out) begin
            st_ff <= ST_IDLE;
          end else if (op_now) begin
            if (param_len(op_code) != 2'h0) begin
              arg_code_ff <= op_code;
              arg_left_ff <= param_len(op_code);
              arg_acc_ff <= 8'h00;
              st_ff <= ST_ARG;
            end else begin
              case (op_code)
                `CMD_SAVE: begin
                  save_ff <= 1'b1;
                  image_ff <= {guard_after_time_ff, guard_before_time_ff, command_idle_timeout_ff,
                               escape_character_ff, power_up_mode_select_ff, signal_strength_pwm_period_ff};
                end
                `CMD_LEAVE: st_ff <= ST_IDLE;
                `CMD_ECHO_DISABLE: echo_ff <= 1'b0;
                `CMD_ECHO_ENABLE: echo_ff <= 1'b1;
                `CMD_FACTORY_RESTORE: begin
                  guard_after_time_ff <= `DEF_GUARD_AFTER;
                  guard_before_time_ff <= `DEF_GUARD_BEFORE;
                  command_idle_timeout_ff <= `DEF_IDLE_TIMEOUT;
                  escape_character_ff <= `DEF_ESCAPE_CHAR;
                  power_up_mode_select_ff <= `DEF_POWER_UP_MODE;
                  signal_strength_pwm_period_ff <= `DEF_PWM_PERIOD;
                end
                default: st_ff <= ST_CMD;
              endcase
            end
          end
        end
        ST_ARG: begin
          if (timed_out) begin
            st_ff <= ST_IDLE;
          end else if (rx_valid) begin
            arg_acc_ff <= rx_data;
            arg_left_ff <= arg_left_ff - 2'h1;
            if (arg_left_ff == 2'h1)
              st_ff <= ST_CMD;
            if (wr_now) begin
              case (arg_code_ff)
                `CMD_GUARD_AFTER: guard_after_time_ff <= wr_val;
                `CMD_GUARD_BEFORE: guard_before_time_ff <= wr_val;
                `CMD_IDLE_TIMEOUT: command_idle_timeout_ff <= wr_val;
                `CMD_ESCAPE_CHAR: escape_character_ff <= rx_data;
                `CMD_POWER_UP_MODE: power_up_mode_select_ff <= rx_data;
                `CMD_PWM_PERIOD: signal_strength_pwm_period_ff <= rx_data;
                default: arg_acc_ff <= rx_data;
              endcase
            end
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
      // wake from pin sleep takes the power-up choice again
      if (wake && st_ff != ST_LOAD)
        st_ff <= power_up_mode_select_ff == `PUM_MAX ? ST_CMD : ST_IDLE;
    end
  end
  // signal-strength pwm: 64 steps per period, each pwm-period slots long, high for rssi steps
  always @(posedge mclk) begin
    if (!rst_n) begin
      slot_cnt_ff <= 24'h000000;
      div_ff <= 7'h00;
      phase_ff <= 6'h00;
      rssi_ff <= 6'h00;
      pwm_ff <= 1'b0;
    end else begin
      if (pkt_good)
        rssi_ff <= pkt_rssi;
      slot_cnt_ff <= slot_cnt_ff == SLOT_LAST ? 24'h000000 : slot_cnt_ff + 24'h000001;
      if (slot_cnt_ff == SLOT_LAST) begin
        if (div_ff + 7'h01 >= signal_strength_pwm_period_ff[6:0]) begin
          div_ff <= 7'h00;
          phase_ff <= phase_ff + 6'h01;
        end else begin
          div_ff <= div_ff + 7'h01;
        end
      end
      pwm_ff <= signal_strength_pwm_period_ff != `DEF_PWM_PERIOD && phase_ff < rssi_ff;
    end
  end
  assign tx_valid = qn_ff != 2'h0;
  assign tx_data = q0_ff;
  assign nvm_save = save_ff;
  assign nvm_wr_image = image_ff;
  assign cmd_mode = in_cmd;
  assign rssi_pwm = pwm_ff;
endmodule

// ===== test/radio_modem_command_mode_assertions.sv
// checker for the modem command handler, bound to its top-level ports
// assumes one mclk domain with a synchronous active-low reset
`timescale 1ns/100ps
module radio_modem_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // host byte streams
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  // store and status
  input wire logic nvm_save,
  input wire logic [71:0] nvm_wr_image,
  input wire logic cmd_mode,
  input wire logic rssi_pwm
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // argument bytes equal to these codes would also match; keep stimulus clear of them
  sequence save_cmd;
    cmd_mode && rx_valid && rx_data == 8'h08;
  endsequence
  sequence leave_cmd;
    cmd_mode && rx_valid && rx_data == 8'h09;
  endsequence
  a_reset_quiet: assert property ($rose(rst_n) |-> !tx_valid && !nvm_save && !cmd_mode && !rssi_pwm)
    else $error("outputs busy after reset");
  a_save_pulse: assert property (save_cmd |=> nvm_save ##1 !nvm_save)
    else $error("save pulse missing");
  a_save_cause: assert property (nvm_save |-> $past(cmd_mode && rx_valid && rx_data == 8'h08))
    else $error("save without command");
  a_image_hold: assert property ($changed(nvm_wr_image) |-> nvm_save)
    else $error("image moved without save");
  a_leave_now: assert property (leave_cmd |=> !cmd_mode)
    else $error("still in command mode");
  a_entry_quiet: assert property ($rose(cmd_mode) |-> !$past(rx_valid))
    else $error("entry without silence");
  a_tx_hold: assert property (tx_valid && !tx_ready && !rx_valid |=> tx_valid && $stable(tx_data))
    else $error("answer byte dropped");
  a_tx_cause: assert property ($rose(tx_valid) |-> $past(cmd_mode && rx_valid))
    else $error("answer without byte");
endmodule
bind radio_modem_command_mode radio_modem_checker u_chk (.mclk(mclk), .rst_n(rst_n), .rx_valid(rx_valid),
  .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .nvm_save(nvm_save),
  .nvm_wr_image(nvm_wr_image), .cmd_mode(cmd_mode), .rssi_pwm(rssi_pwm));

// ===== test/radio_modem_host.sv
// host model on the serial byte ports of the command handler
// assumes one answer queue that must drain before the next byte
`timescale 1ns/100ps
module radio_modem_host (
  // clock
  input wire logic mclk,
  // to the handler
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_ready,
  // from the handler
  input wire logic tx_valid,
  input wire logic [7:0] tx_data
);
  logic [7:0] got[$];
  logic slow;
  int hangs;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
    slow = 1'b0;
    hangs = 0;
  end
  // slow host takes a byte only every other cycle
  always @(negedge mclk) tx_ready <= slow ? ~tx_ready : 1'b1;
  always @(posedge mclk) if (tx_valid && tx_ready) got.push_back(tx_data);
  task automatic send(input logic [7:0] b);
    int n;
    @(negedge mclk);
    rx_valid = 1'b1;
    rx_data = b;
    @(negedge mclk);
    rx_valid = 1'b0;
    rx_data = ~b;
    @(negedge mclk);
    n = 0;
    while (tx_valid === 1'b1 && n < 64) begin
      @(negedge mclk);
      n++;
    end
    if (n == 64) hangs++;
  endtask
  task automatic quiet(input int ticks);
    repeat (ticks * 64) @(negedge mclk);
  endtask
  // stops short of the guard-after time so the caller can look before entry
  task automatic escape(input logic [7:0] esc);
    quiet(12);
    repeat (3) send(esc);
    quiet(8);
  endtask
endmodule

// ===== test/radio_modem_command_mode_tb_top.sv
// testbench for the modem command handler with a host model
// assumes 64-cycle ticks and 1-cycle pwm slots to keep runs short
`timescale 1ns/100ps
module radio_modem_command_mode_tb_top;
  logic mclk, rst_n, rx_valid, tx_valid, tx_ready, pkt_good, pkt_err, nvm_present, nvm_save, wake;
  logic cmd_mode, rssi_pwm;
  logic [7:0] rx_data, tx_data;
  logic [5:0] pkt_rssi;
  logic [71:0] nvm_rd_image, nvm_wr_image, img;
  int err_count, tests_run, saves, n;
  radio_modem_command_mode #(.TICK_CYCLES(24'd64), .SLOT_CYCLES(24'd1)) dut (.mclk(mclk), .rst_n(rst_n),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .pkt_good(pkt_good), .pkt_err(pkt_err), .pkt_rssi(pkt_rssi), .nvm_present(nvm_present),
    .nvm_rd_image(nvm_rd_image), .nvm_save(nvm_save), .nvm_wr_image(nvm_wr_image), .wake(wake),
    .cmd_mode(cmd_mode), .rssi_pwm(rssi_pwm));
  radio_modem_host host (.mclk(mclk), .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data));
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) if (nvm_save === 1'b1) begin
    saves++;
    img = nvm_wr_image;
  end
  task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    err_count += host.hangs;
    $display("mismatches %0d comparisons %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [6:0] c, input int k, input logic [15:0] v);
    host.send({1'b0, c});
    if (k == 2) host.send(v[15:8]);
    if (k > 0) host.send(v[7:0]);
  endtask
  task automatic rd(input logic [6:0] c, input int k, input logic [15:0] exp, input logic echo);
    int e;
    host.got.delete();
    host.send({1'b1, c});
    e = echo ? 1 : 0;
    chk(host.got.size(), k + e);
    if (echo) chk(host.got[0], {1'b1, c});
    chk((k == 2) ? {host.got[e], host.got[e + 1]} : {8'h00, host.got[e]}, exp);
  endtask
  task automatic pkt(input logic g, input logic e);
    @(negedge mclk);
    pkt_good = g;
    pkt_err = e;
    @(negedge mclk);
    pkt_good = 1'b0;
    pkt_err = 1'b0;
  endtask
  task automatic enter();
    host.escape(8'h2b);
    chk(cmd_mode, 1'b0);
    host.quiet(4);
    chk(cmd_mode, 1'b1);
  endtask
  initial begin
    repeat (100000) @(posedge mclk);
    err_count++;
    end_of_test();
  end
  initial begin
    {mclk, rst_n, pkt_good, pkt_err, nvm_present, wake, saves, err_count, tests_run} = '0;
    pkt_rssi = 6'h20;
    nvm_rd_image = '0;
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    chk(cmd_mode, 1'b0);
    enter();
    rd(7'h04, 2, 16'h000a, 1);
    rd(7'h05, 2, 16'h000a, 1);
    rd(7'h06, 2, 16'h00c8, 1);
    rd(7'h13, 1, 16'h002b, 1);
    rd(7'h1e, 1, 16'h0000, 1);
    rd(7'h22, 1, 16'h0000, 1);
    wr(7'h13, 1, 16'h002d);
    wr(7'h13, 1, 16'h001f);
    rd(7'h13, 1, 16'h002d, 1);
    repeat (3) pkt(1'b1, 1'b0);
    repeat (2) pkt(1'b0, 1'b1);
    rd(7'h10, 2, 16'h0003, 1);
    wr(7'h0f, 2, 16'h0000);
    rd(7'h0f, 2, 16'h0000, 1);
    rd(7'h10, 2, 16'h0003, 1);
    wr(7'h10, 2, 16'h0005);
    rd(7'h10, 2, 16'h0000, 1);
    wr(7'h0a, 0, 16'h0000);
    host.slow = 1'b1;
    rd(7'h04, 2, 16'h000a, 0);
    host.slow = 1'b0;
    wr(7'h0b, 0, 16'h0000);
    rd(7'h04, 2, 16'h000a, 1);
    // half-strength packet over 64 one-cycle slots: 32 high per period
    wr(7'h22, 1, 16'h0001);
    n = 0;
    repeat (640) @(negedge mclk) if (rssi_pwm === 1'b1) n++;
    chk(n, 320);
    wr(7'h1e, 1, 16'h0001);
    wr(7'h08, 0, 16'h0000);
    chk(saves, 1);
    chk(img, {16'h000a, 16'h000a, 16'h00c8, 8'h2d, 8'h01, 8'h01});
    wr(7'h05, 2, 16'h0014);
    rd(7'h05, 2, 16'h0014, 1);
    wr(7'h04, 2, 16'h0003);
    rd(7'h04, 2, 16'h0003, 1);
    wr(7'h0e, 0, 16'h0000);
    rd(7'h13, 1, 16'h002b, 1);
    rd(7'h22, 1, 16'h0000, 1);
    chk(rssi_pwm, 1'b0);
    rd(7'h05, 2, 16'h000a, 1);
    rd(7'h04, 2, 16'h000a, 1);
    wr(7'h09, 0, 16'h0000);
    chk(cmd_mode, 1'b0);
    enter();
    wr(7'h06, 2, 16'h0002);
    chk(cmd_mode, 1'b1);
    host.quiet(4);
    chk(cmd_mode, 1'b0);
    @(negedge mclk);
    rst_n = 1'b0;
    nvm_present = 1'b1;
    nvm_rd_image = img;
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    chk(cmd_mode, 1'b1);
    rd(7'h13, 1, 16'h002d, 1);
    rd(7'h10, 2, 16'h0000, 1);
    // wake from pin sleep takes the stored power-up choice again
    wr(7'h09, 0, 16'h0000);
    chk(cmd_mode, 1'b0);
    @(negedge mclk);
    wake = 1'b1;
    @(negedge mclk);
    wake = 1'b0;
    chk(cmd_mode, 1'b1);
    end_of_test();
  end
endmodule
